// ---- core/mtc_top.sv ----
// Notes on behaviour
// RULE1: Channel step mantissa has hidden leading one
// RULE2: Step mantissa register bits 7:0, reset F8
// RULE3: FSK deviation mantissa has hidden leading one
// RULE4: Exponent 6:4 reset 4, mantissa 2:0 reset 7
// RULE5: MSK uses mantissa as phase-change fraction
// RULE6: After packet: idle, synth-on, or stay TX
// RULE7: Software never writes 11 to next-state field
// RULE8: Policy 00 calibrates only on calibrate strobe
// RULE9: Policy 01 calibrates when leaving IDLE
// RULE10: Policy 10 each return, 11 every fourth
module mtc_top
#(
    parameter int CAL_CYCLES = mtc_pkg::CAL_CYCLES_DEF
)
(
    input  wire logic                             i_clk,
    input  wire logic                             i_rstn,
    input  mtc_pkg::mtc_reg_req_t                 i_reg_req,
    output logic      [7:0]                       o_reg_rdata,
    input  wire logic                             i_tx_strobe,
    input  wire logic                             i_synth_on_strobe,
    input  wire logic                             i_idle_strobe,
    input  wire logic                             i_calibrate_strobe,
    input  wire logic                             i_pkt_done,
    input  wire logic [1:0]                       i_channel_number_step_exponent,
    input  wire logic [7:0]                       i_channel_number,
    input  wire logic [2:0]                       i_mod_format,
    output mtc_pkg::mtc_state_t                   o_state,
    output logic                                  o_cal_busy,
    output logic                                  o_preamble_start,
    output logic      [mtc_pkg::CHANNEL_NUMBER_OFS_W-1:0]   o_channel_number_offset,
    output logic      [mtc_pkg::DEV_WORD_W-1:0]   o_dev_word,
    output logic      [2:0]                       o_msk_phase_frac
);
    import mtc_pkg::*;

    if (CAL_CYCLES < 1 || CAL_CYCLES > 256)
    begin : g_cal_check
        $error("CAL_CYCLES must lie in 1..256");
    end

    localparam logic [7:0] CAL_LAST = 8'(CAL_CYCLES - 1);

    mtc_cfg_t   cfg_r;
    logic [7:0] rdata_nxt;
    logic [7:0] rdata_r;
    mtc_state_t state_r;
    mtc_state_t state_nxt;
    mtc_state_t cal_ret_r;
    mtc_state_t cal_ret_nxt;
    mtc_state_t go_target;
    logic [7:0] cal_cnt_r;
    logic       preamble_r;
    logic       leave_idle;
    logic       tx_to_idle;
    logic       tx_done;
    logic       cal_req;

    // Register writes
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cfg_r.channel_number_step_mantissa      <= RST_CHANNEL_NUMBER_MANT;                    // RULE2
            cfg_r.dev_exponent            <= RST_DEV_EXP;                      // RULE4
            cfg_r.dev_mantissa            <= RST_DEV_MANT;                     // RULE4
            cfg_r.after_tx_next_state     <= AFTER_IDLE;                       // RULE6
            cfg_r.auto_calibration_policy <= CAL_NEVER;                        // RULE8
        end
        else if (i_reg_req.wr)
        begin
            unique case (i_reg_req.addr)
                ADDR_CHANNEL_NUMBER_MANT:
                    cfg_r.channel_number_step_mantissa <= i_reg_req.wdata;               // RULE2
                ADDR_DEV:
                begin
                    cfg_r.dev_exponent <= i_reg_req.wdata[DEV_EXP_LSB +: 3];   // RULE4
                    cfg_r.dev_mantissa <= i_reg_req.wdata[DEV_MANT_LSB +: 3];  // RULE4
                end
                ADDR_SM_ONE:
                    cfg_r.after_tx_next_state <=
                        mtc_after_tx_t'(i_reg_req.wdata[AFTER_TX_LSB +: 2]);   // RULE6
                ADDR_SM_ZERO:
                    cfg_r.auto_calibration_policy <=
                        mtc_autocal_t'(i_reg_req.wdata[AUTOCAL_LSB +: 2]);     // RULE8
                default:
                begin
                end
            endcase
        end
    end

    // Read mux; reserved bits and unmapped addresses read zero
    always_comb
    begin
        rdata_nxt = 8'h00;
        unique case (i_reg_req.addr)
            ADDR_CHANNEL_NUMBER_MANT:
                rdata_nxt = cfg_r.channel_number_step_mantissa;                          // RULE2
            ADDR_DEV:
            begin
                rdata_nxt[DEV_EXP_LSB +: 3]  = cfg_r.dev_exponent;             // RULE4
                rdata_nxt[DEV_MANT_LSB +: 3] = cfg_r.dev_mantissa;             // RULE4
            end
            ADDR_SM_ONE:
                rdata_nxt[AFTER_TX_LSB +: 2] = cfg_r.after_tx_next_state;
            ADDR_SM_ZERO:
                rdata_nxt[AUTOCAL_LSB +: 2] = cfg_r.auto_calibration_policy;
            default:
                rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            rdata_r <= 8'h00;
        else
            rdata_r <= rdata_nxt;
    end

    assign o_reg_rdata = rdata_r;

    // Transition events, kept apart from the next-state logic to avoid a loop
    // through the calibration scheduler
    always_comb
    begin
        leave_idle = (state_r == ST_IDLE) && !i_calibrate_strobe
                     && (i_tx_strobe || i_synth_on_strobe);
        go_target  = i_tx_strobe ? ST_TX : ST_SYNTH_ON;
        tx_done    = (state_r == ST_TX) && i_pkt_done && !i_idle_strobe;
        // The unused code falls back to IDLE, the safest place to park
        tx_to_idle = (state_r == ST_TX) && (i_idle_strobe
                     || (tx_done && (cfg_r.after_tx_next_state == AFTER_IDLE
                     || cfg_r.after_tx_next_state == AFTER_RX_UNUSED))); // RULE7
    end

    mtc_cal_sched u_cal_sched
    (
        .i_clk        (i_clk),
        .i_rstn       (i_rstn),
        .i_policy     (cfg_r.auto_calibration_policy),
        .i_leave_idle (leave_idle),
        .i_tx_to_idle (tx_to_idle),
        .o_cal_req    (cal_req)
    );

    always_comb
    begin
        state_nxt   = state_r;
        cal_ret_nxt = cal_ret_r;
        unique case (state_r)
            ST_IDLE:
            begin
                if (i_calibrate_strobe)
                begin
                    state_nxt   = ST_CAL;                                      // RULE8
                    cal_ret_nxt = ST_IDLE;
                end
                else if (leave_idle && cal_req)
                begin
                    state_nxt   = ST_CAL;                                      // RULE9
                    cal_ret_nxt = go_target;
                end
                else if (leave_idle)
                    state_nxt = go_target;
            end
            ST_SYNTH_ON:
            begin
                if (i_tx_strobe)
                    state_nxt = ST_TX;
                else if (i_idle_strobe)
                    state_nxt = ST_IDLE;
            end
            ST_TX:
            begin
                if (tx_to_idle && cal_req)
                begin
                    state_nxt   = ST_CAL;                                      // RULE10
                    cal_ret_nxt = ST_IDLE;
                end
                else if (tx_to_idle)
                    state_nxt = ST_IDLE;                                       // RULE6
                else if (tx_done && cfg_r.after_tx_next_state == AFTER_SYNTH_ON)
                    state_nxt = ST_SYNTH_ON;                                   // RULE6
            end
            ST_CAL:
            begin
                if (cal_cnt_r == CAL_LAST)
                    state_nxt = cal_ret_r;
            end
            default:
            begin
                state_nxt   = ST_IDLE;
                cal_ret_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_r   <= ST_IDLE;
            cal_ret_r <= ST_IDLE;
        end
        else
        begin
            state_r   <= state_nxt;
            cal_ret_r <= cal_ret_nxt;
        end
    end

    // Calibration length counter; strobes are ignored while it runs
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            cal_cnt_r <= 8'h00;
        else if (state_r == ST_CAL && cal_cnt_r != CAL_LAST)
            cal_cnt_r <= cal_cnt_r + 8'h01;
        else
            cal_cnt_r <= 8'h00;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            preamble_r <= 1'b0;
        else
            preamble_r <= tx_done && cfg_r.after_tx_next_state == AFTER_STAY_TX; // RULE6
    end

    assign o_state          = state_r;
    assign o_cal_busy       = (state_r == ST_CAL);
    assign o_preamble_start = preamble_r;

    mtc_calc u_calc
    (
        .i_clk                (i_clk),
        .i_rstn               (i_rstn),
        .i_cfg                (cfg_r),
        .i_channel_number_step_exponent (i_channel_number_step_exponent),
        .i_channel_number     (i_channel_number),
        .i_mod_format         (i_mod_format),
        .o_channel_number_offset        (o_channel_number_offset),
        .o_dev_word           (o_dev_word),
        .o_msk_phase_frac     (o_msk_phase_frac)
    );

    AST_MANT_RESET: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE2
        $rose(i_rstn) |-> cfg_r.channel_number_step_mantissa == RST_CHANNEL_NUMBER_MANT
            && cfg_r.dev_exponent == RST_DEV_EXP && cfg_r.dev_mantissa == RST_DEV_MANT)
        else $error("Configuration reset values wrong");

    AST_MANT_READBACK: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE2
        i_reg_req.wr && i_reg_req.addr == ADDR_CHANNEL_NUMBER_MANT
            ##1 i_reg_req.addr == ADDR_CHANNEL_NUMBER_MANT && !i_reg_req.wr
            |=> o_reg_rdata == $past(i_reg_req.wdata, 2))
        else $error("Step mantissa read back differs from write");

    AST_DEV_RESERVED: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE4
        i_reg_req.addr == ADDR_DEV && !i_reg_req.wr |=> o_reg_rdata[7] == 1'b0
            && o_reg_rdata[3] == 1'b0 && o_reg_rdata[6:4] == cfg_r.dev_exponent
            && o_reg_rdata[2:0] == cfg_r.dev_mantissa)
        else $error("Deviation register read wrong");

    AST_TXOFF_SYNTH: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE6
        tx_done && cfg_r.after_tx_next_state == AFTER_SYNTH_ON |=> state_r == ST_SYNTH_ON)
        else $error("Did not enter synth-on after packet");

    AST_TXOFF_STAY: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE6
        tx_done && cfg_r.after_tx_next_state == AFTER_STAY_TX
            |=> state_r == ST_TX && o_preamble_start ##1 !o_preamble_start)
        else $error("Stay-in-TX did not restart preamble once");

    AST_NO_AUTOCAL: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE8
        cfg_r.auto_calibration_policy == CAL_NEVER && leave_idle |=> state_r == $past(go_target))
        else $error("Calibration ran with automatic calibration off");

    AST_STROBE_CAL: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE8
        state_r == ST_IDLE && i_calibrate_strobe |=> o_cal_busy && cal_ret_r == ST_IDLE)
        else $error("Calibrate strobe ignored in IDLE");

    AST_CAL_ON_START: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE9
        cfg_r.auto_calibration_policy == CAL_ON_START && leave_idle
            |=> state_r == ST_CAL && cal_ret_r == $past(go_target))
        else $error("No calibration when leaving IDLE");

    AST_CAL_ON_RETURN: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE10
        cfg_r.auto_calibration_policy == CAL_ON_IDLE && tx_to_idle
            |=> state_r == ST_CAL ##[1:256] state_r == ST_IDLE)
        else $error("No calibration on return to IDLE");

    COV_STAY_TX: cover property (@(posedge i_clk) disable iff (!i_rstn)
        tx_done && cfg_r.after_tx_next_state == AFTER_STAY_TX);

    COV_START_CAL: cover property (@(posedge i_clk) disable iff (!i_rstn)
        leave_idle && cal_req ##[1:256] state_r == ST_TX);

    COV_FOURTH_CAL: cover property (@(posedge i_clk) disable iff (!i_rstn)
        cfg_r.auto_calibration_policy == CAL_EVERY_4TH && tx_to_idle && cal_req);

endmodule

// ---- core/mtc_pkg.sv ----
package mtc_pkg;

    // Register offsets on the serial register port
    localparam logic [5:0] ADDR_CHANNEL_NUMBER_MANT = 6'h14;
    localparam logic [5:0] ADDR_DEV       = 6'h15;
    localparam logic [5:0] ADDR_SM_ONE    = 6'h17;
    localparam logic [5:0] ADDR_SM_ZERO   = 6'h18;

    // Field positions
    localparam int DEV_EXP_LSB   = 4;
    localparam int DEV_MANT_LSB  = 0;
    localparam int AFTER_TX_LSB  = 0;
    localparam int AUTOCAL_LSB   = 4;

    // Reset values
    localparam logic [7:0] RST_CHANNEL_NUMBER_MANT = 8'hF8;
    localparam logic [2:0] RST_DEV_EXP   = 3'h4;
    localparam logic [2:0] RST_DEV_MANT  = 3'h7;

    // Arithmetic constants
    localparam int CHANNEL_NUMBER_OFS_W  = 20;
    localparam int DEV_WORD_W  = 11;
    localparam logic [2:0] MOD_MSK = 3'h7;

    // Calibration timing and every-fourth schedule
    localparam int CAL_CYCLES_DEF      = 8;
    localparam logic [1:0] CAL_NTH_LAST = 2'h3;

    typedef enum logic [1:0]
    {
        AFTER_IDLE      = 2'h0,
        AFTER_SYNTH_ON  = 2'h1,
        AFTER_STAY_TX   = 2'h2,
        AFTER_RX_UNUSED = 2'h3
    } mtc_after_tx_t;

    typedef enum logic [1:0]
    {
        CAL_NEVER     = 2'h0,
        CAL_ON_START  = 2'h1,
        CAL_ON_IDLE   = 2'h2,
        CAL_EVERY_4TH = 2'h3
    } mtc_autocal_t;

    typedef enum logic [3:0]
    {
        ST_IDLE     = 4'h1,
        ST_SYNTH_ON = 4'h2,
        ST_TX       = 4'h4,
        ST_CAL      = 4'h8
    } mtc_state_t;

    typedef struct packed
    {
        logic [7:0]    channel_number_step_mantissa;
        logic [2:0]    dev_exponent;
        logic [2:0]    dev_mantissa;
        mtc_after_tx_t after_tx_next_state;
        mtc_autocal_t  auto_calibration_policy;
    } mtc_cfg_t;

    typedef struct packed
    {
        logic       wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } mtc_reg_req_t;

endpackage

// ---- core/mtc_calc.sv ----
module mtc_calc
(
    input  wire logic                             i_clk,
    input  wire logic                             i_rstn,
    input  mtc_pkg::mtc_cfg_t                     i_cfg,
    input  wire logic [1:0]                       i_channel_number_step_exponent,
    input  wire logic [7:0]                       i_channel_number,
    input  wire logic [2:0]                       i_mod_format,
    output logic      [mtc_pkg::CHANNEL_NUMBER_OFS_W-1:0]   o_channel_number_offset,
    output logic      [mtc_pkg::DEV_WORD_W-1:0]   o_dev_word,
    output logic      [2:0]                       o_msk_phase_frac
);
    import mtc_pkg::*;

    logic [8:0]            step_full;
    logic [11:0]           step_scaled;
    logic [3:0]            dev_full;
    logic                  is_msk;

    // Hidden leading one on both mantissas
    assign step_full   = {1'b1, i_cfg.channel_number_step_mantissa};                     // RULE1
    assign step_scaled = 12'(step_full) << i_channel_number_step_exponent;               // RULE1
    assign dev_full    = {1'b1, i_cfg.dev_mantissa};                           // RULE3
    assign is_msk      = (i_mod_format == MOD_MSK);

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_channel_number_offset <= '0;
        else
            o_channel_number_offset <= 20'(step_scaled) * 20'(i_channel_number);        // RULE1
    end

    // Deviation word is forced to zero in MSK so the modulator cannot mix both uses
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_dev_word       <= '0;
            o_msk_phase_frac <= '0;
        end
        else if (is_msk)
        begin
            o_dev_word       <= '0;                                            // RULE5
            o_msk_phase_frac <= i_cfg.dev_mantissa;                            // RULE5
        end
        else
        begin
            o_dev_word       <= 11'(dev_full) << i_cfg.dev_exponent;           // RULE3
            o_msk_phase_frac <= '0;
        end
    end

    AST_CHANNEL_NUMBER_OFFSET: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE1
        $past(i_rstn) |-> int'(o_channel_number_offset) == (256 + int'($past(i_cfg.channel_number_step_mantissa)))
            * (1 << $past(i_channel_number_step_exponent)) * int'($past(i_channel_number)))
        else $error("Channel offset does not follow spacing formula");

    AST_DEV_WORD: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE3
        $past(i_rstn) && $past(i_mod_format) != MOD_MSK |->
            int'(o_dev_word) == (8 + int'($past(i_cfg.dev_mantissa))) * (1 << $past(i_cfg.dev_exponent)))
        else $error("Deviation word does not follow deviation formula");

    AST_MSK_FRAC: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE5
        i_mod_format == MOD_MSK |=> o_dev_word == '0 && o_msk_phase_frac == $past(i_cfg.dev_mantissa))
        else $error("MSK mode did not route mantissa to phase fraction");

endmodule

// ---- core/mtc_cal_sched.sv ----
module mtc_cal_sched
(
    input  wire logic                   i_clk,
    input  wire logic                   i_rstn,
    input  mtc_pkg::mtc_autocal_t       i_policy,
    input  wire logic                   i_leave_idle,
    input  wire logic                   i_tx_to_idle,
    output logic                        o_cal_req
);
    import mtc_pkg::*;

    logic [1:0] ret_cnt_r;

    // Counts every TX-to-IDLE return, so a policy switch keeps the running phase
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            ret_cnt_r <= 2'h0;
        else if (i_tx_to_idle)
            ret_cnt_r <= ret_cnt_r + 2'h1;                                     // RULE10
    end

    always_comb
    begin
        unique case (i_policy)
            CAL_NEVER:     o_cal_req = 1'b0;                                   // RULE8
            CAL_ON_START:  o_cal_req = i_leave_idle;                           // RULE9
            CAL_ON_IDLE:   o_cal_req = i_tx_to_idle;                           // RULE10
            CAL_EVERY_4TH: o_cal_req = i_tx_to_idle && ret_cnt_r == CAL_NTH_LAST; // RULE10
        endcase
    end

    AST_FOURTH_WRAP: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE10
        o_cal_req && i_policy == CAL_EVERY_4TH |=> ret_cnt_r == 2'h0 ##0 !o_cal_req)
        else $error("Every-fourth calibration out of phase");

endmodule

// ---- bench/mtc_host.sv ----
module mtc_host
(
    input  wire logic             i_clk,
    output mtc_pkg::mtc_reg_req_t o_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import mtc_pkg::*;

    initial
    begin
        o_req = '{wr: 1'b0, addr: 6'h00, wdata: 8'h00};
    end

    // Strobe and data stand for exactly one rising edge
    task automatic write(input logic [5:0] a, input logic [7:0] d);
        o_req.wr    = 1'b1;
        o_req.addr  = a;
        o_req.wdata = (a == ADDR_SM_ONE && d[1:0] == 2'h3) ? (d & 8'hFE) : d;
        @(negedge i_clk);
        o_req.wr    = 1'b0;
        // Released data lines must not keep the last byte
        o_req.wdata = ~d;
        // An idle edge between writes keeps the strobe from toggling in zero time
        @(negedge i_clk);
    endtask

    // Read data follows the address every cycle
    task automatic point(input logic [5:0] a);
        o_req.addr = a;
    endtask
endmodule

// ---- bench/modulator_and_txoff_config_bench.sv ----
module modulator_and_txoff_config_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import mtc_pkg::*;

    localparam int         CC    = 4;
    localparam logic [4:0] V_CAL = 5'h10;
    localparam logic [4:0] V_TX  = 5'h08;
    localparam logic [4:0] V_SYN = 5'h04;
    localparam logic [4:0] V_IDL = 5'h02;
    localparam logic [4:0] V_PKT = 5'h01;

    typedef struct packed
    {
        logic [2:0]  kind;
        logic [19:0] val;
        int          due;
    } mtc_note_t;

    logic         i_clk;
    logic         i_rstn;
    mtc_reg_req_t req;
    logic [4:0]   strb;
    logic [1:0]   cexp;
    logic [7:0]   channel_number;
    logic [2:0]   fmt;
    logic [7:0]   rdata;
    mtc_state_t   state;
    logic         busy;
    logic         pre;
    logic [19:0]  ofs;
    logic [10:0]  dw;
    logic [2:0]   frac;
    int           failures;
    int           samples_checked;
    int           cyc;
    int           rets;
    int           qi;
    logic [31:0]  lf;
    logic [1:0]   pol;
    logic [7:0]   m;
    mtc_note_t    q[$];
    string        nm[7] = '{"rdata", "state", "preamble", "offset", "devword", "mskfrac", "busy"};

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    mtc_top #(.CAL_CYCLES(CC)) mtc_top_inst
    (
        .i_clk                (i_clk),
        .i_rstn               (i_rstn),
        .i_reg_req            (req),
        .o_reg_rdata          (rdata),
        .i_tx_strobe          (strb[3]),
        .i_synth_on_strobe    (strb[2]),
        .i_idle_strobe        (strb[1]),
        .i_calibrate_strobe   (strb[4]),
        .i_pkt_done           (strb[0]),
        .i_channel_number_step_exponent (cexp),
        .i_channel_number     (channel_number),
        .i_mod_format         (fmt),
        .o_state              (state),
        .o_cal_busy           (busy),
        .o_preamble_start     (pre),
        .o_channel_number_offset        (ofs),
        .o_dev_word           (dw),
        .o_msk_phase_frac     (frac)
    );

    mtc_host mtc_host_inst
    (
        .i_clk (i_clk),
        .o_req (req)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [19:0] get(input logic [2:0] k);
        case (k)
            3'h0: return 20'(rdata);
            3'h1: return 20'(state);
            3'h2: return 20'(pre);
            3'h3: return ofs;
            3'h4: return 20'(dw);
            3'h5: return 20'(frac);
            default: return 20'(busy);
        endcase
    endfunction

    task automatic give_verdict();
        // Notes that never came due count as mismatches
        failures += q.size();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic step();
        @(negedge i_clk);
    endtask

    task automatic note(input logic [2:0] k, input logic [19:0] v, input int d);
        q.push_back('{k, v, cyc + d});
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        mtc_host_inst.write(a, d);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        mtc_host_inst.point(a);
        note(3'h0, 20'(e), 1);
        step();
    endtask

    task automatic cmd(input logic [4:0] v, input mtc_state_t nx, input logic c);
        if (c)
        begin
            note(3'h1, 20'(ST_CAL), 1);
            note(3'h6, 20'h1, 1);
            note(3'h6, 20'h0, CC + 1);
        end
        note(3'h1, 20'(nx), c ? CC + 1 : 1);
        strb = v;
        step();
        strb = 5'h00;
        // One quiet edge so a following command never re-raises a strobe in zero time
        step();
        // Strobes during calibration would be ignored, so wait it out
        if (c)
            repeat (CC - 1) step();
    endtask

    // Every return from TX counts toward the every-fourth schedule
    task automatic back(input logic [4:0] v);
        rets++;
        cmd(v, ST_IDLE, pol[1] && (!pol[0] || rets % 4 == 0));
    endtask

    task automatic setcfg(input logic [1:0] a, input logic [1:0] p);
        wr(ADDR_SM_ONE, {6'h00, a});
        wr(ADDR_SM_ZERO, {2'h0, p, 4'h0});
        pol = p;
    endtask

    always @(negedge i_clk)
    begin
        qi = 0;
        while (qi < q.size())
        begin
            if (q[qi].due == cyc)
            begin
                samples_checked++;
                if (get(q[qi].kind) !== q[qi].val)
                begin
                    failures++;
                    $display("mismatch %s expected %h seen %h", nm[q[qi].kind], q[qi].val,
                             get(q[qi].kind));
                end
                q.delete(qi);
            end
            else
                qi++;
        end
    end

    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            failures++;
            give_verdict();
        end
    end

    initial
    begin
        i_rstn = 1'b0;
        strb   = 5'h00;
        cexp   = 2'h2;
        channel_number   = 8'h05;
        fmt    = 3'h0;
        lf     = 32'h3343;
        pol    = 2'h0;
        repeat (10) @(posedge i_clk);
        step();
        i_rstn = 1'b1;
        note(3'h1, 20'(ST_IDLE), 1);
        note(3'h3, 20'd10080, 1);
        note(3'h4, 20'd240, 1);
        step();
        rd(ADDR_CHANNEL_NUMBER_MANT, RST_CHANNEL_NUMBER_MANT);
        rd(ADDR_DEV, {1'b0, RST_DEV_EXP, 1'b0, RST_DEV_MANT});
        rd(ADDR_SM_ONE, 8'h00);
        rd(ADDR_SM_ZERO, 8'h00);
        repeat (4)
        begin
            lf = lfsr_next(lf);
            m  = lf[7:0];
            wr(ADDR_CHANNEL_NUMBER_MANT, m);
            rd(ADDR_CHANNEL_NUMBER_MANT, m);
            wr(ADDR_DEV, m);
            rd(ADDR_DEV, m & 8'h77);
            wr(ADDR_SM_ONE, m & 8'hFE);
            rd(ADDR_SM_ONE, m & 8'h02);
            wr(ADDR_SM_ZERO, m);
            rd(ADDR_SM_ZERO, m & 8'h30);
            wr(6'h16, m);
            rd(6'h16, 8'h00);
        end
        repeat (6)
        begin
            lf   = lfsr_next(lf);
            m    = lf[7:0];
            cexp = lf[9:8];
            channel_number = lf[17:10];
            fmt  = lf[18] ? MOD_MSK : {2'h0, lf[19]};
            note(3'h3, 20'((256 + int'(m)) * (1 << cexp) * int'(channel_number)), 2);
            wr(ADDR_CHANNEL_NUMBER_MANT, m);
            note(3'h4, fmt == MOD_MSK ? 20'h0 : 20'((8 + int'(lf[22:20])) << lf[26:24]), 2);
            note(3'h5, fmt == MOD_MSK ? 20'(lf[22:20]) : 20'h0, 2);
            wr(ADDR_DEV, {1'b0, lf[26:24], 1'b0, lf[22:20]});
        end
        setcfg(2'h0, 2'h0);
        cmd(V_TX, ST_TX, 1'b0);
        cmd(V_CAL, ST_TX, 1'b0);
        back(V_PKT);
        cmd(V_CAL, ST_IDLE, 1'b1);
        setcfg(2'h1, 2'h0);
        cmd(V_TX, ST_TX, 1'b0);
        cmd(V_PKT, ST_SYNTH_ON, 1'b0);
        cmd(V_TX, ST_TX, 1'b0);
        setcfg(2'h2, 2'h0);
        note(3'h2, 20'h1, 1);
        note(3'h2, 20'h0, 2);
        cmd(V_PKT, ST_TX, 1'b0);
        back(V_IDL);
        setcfg(2'h0, 2'h1);
        cmd(V_TX, ST_TX, 1'b1);
        back(V_IDL);
        cmd(V_SYN, ST_SYNTH_ON, 1'b1);
        cmd(V_IDL, ST_IDLE, 1'b0);
        setcfg(2'h0, 2'h2);
        cmd(V_TX, ST_TX, 1'b0);
        back(V_PKT);
        setcfg(2'h0, 2'h3);
        repeat (4)
        begin
            cmd(V_TX, ST_TX, 1'b0);
            back(V_PKT);
        end
        repeat (3) step();
        give_verdict();
    end
endmodule
